// file: core/ssc_pkg.sv
// Shared constants and types for the synchronous memory control-input block.
// Assumes a single clock domain; the timing figures are counts of clock edges.
package ssc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W_DEF  = 19;
  localparam int LANES       = 4;
  localparam int BYTE_W      = 8;
  localparam int LANE_W      = BYTE_W + 1;
  localparam int DATA_W      = LANES * BYTE_W;
  localparam int BURST_W     = 2;

  // ----------------------------------------------------------------
  // Pipeline timing, in recognised clock edges after the address edge
  // ----------------------------------------------------------------
  localparam int READ_LATENCY  = 2;
  localparam int WRITE_LATENCY = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [LANES-1:0]   LANES_RST = 4'h0;

  // Operation carried by a pipeline stage.
  typedef enum logic [2:0] {
    SSC_IDLE  = 3'b001,
    SSC_READ  = 3'b010,
    SSC_WRITE = 3'b100
  } ssc_op_t;

endpackage : ssc_pkg

// file: core/ssc_mem.sv
// Lane-masked storage array with a registered read port.
// Assumes the caller qualifies both ports with the clock-enable term.
`timescale 1ns/1ps
`default_nettype none
module ssc_mem #(
  parameter int ADDR_W = ssc_pkg::ADDR_W_DEF
) (
  // Clock
  input  wire logic                                     ref_clk,
  // Write port
  input  wire logic                                     wr_en,
  input  wire logic [ADDR_W-1:0]                        wr_addr,
  input  wire logic [ssc_pkg::LANES-1:0]                wr_lane_en,
  input  wire logic [ssc_pkg::LANES*ssc_pkg::LANE_W-1:0] wr_data,
  // Read port
  input  wire logic                                     rd_en,
  input  wire logic [ADDR_W-1:0]                        rd_addr,
  output logic      [ssc_pkg::LANES*ssc_pkg::LANE_W-1:0] rd_data_reg
);
  import ssc_pkg::*;

  logic [LANES*LANE_W-1:0] store [0:(1<<ADDR_W)-1];
  logic [LANES*LANE_W-1:0] rd_data_next;

  // ----------------------------------------------------------------
  // Write with per-lane masking
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (wr_en && wr_lane_en[i])
      begin
        store[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered read
  // ----------------------------------------------------------------
  // A read on the same edge as a write to the same word takes the new
  // lanes, so back-to-back write then read never returns stale data.
  always_comb
  begin
    rd_data_next = store[rd_addr];
    for (int i = 0; i < LANES; i++)
    begin
      if (wr_en && wr_lane_en[i] && (wr_addr == rd_addr))
      begin
        rd_data_next[i*LANE_W +: LANE_W] = wr_data[i*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rd_en)
    begin
      rd_data_reg <= rd_data_next;
    end
  end

endmodule : ssc_mem
`default_nettype wire

// file: core/ssc_top.sv
// Pipelined burst memory: control-input capture, burst addressing and
// the two-stage read/write data pipeline with no turnaround cycle.
// Assumes every input is synchronous to ref_clk; data pins are split
// into input, output and enable, resolved by the surroundings.
//
// Overview of operation
// - Capture address, select one location.
// - Lane selects active low, with write strobe.
// - Each lane select owns byte and parity.
// - Write strobe sampled only when qualified.
// - Advance high: step internal burst counter.
// - Advance low: load new external address.
// - Unqualified edges capture nothing.
// - First select active low, combined.
// - Second select active high, combined.
// - Third select high deselects device.
// - Clock qualify stretches, never deselects.
// - Strap picks interleaved or linear order.
// - Data floats on writes and deselect.
`timescale 1ns/1ps
`default_nettype none
module ssc_top #(
  parameter int ADDR_W = ssc_pkg::ADDR_W_DEF
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  // Address
  input  wire logic                        addr_bit_zero,
  input  wire logic                        addr_bit_one,
  input  wire logic [ADDR_W-3:0]           addr_upper,
  // Write control
  input  wire logic                        lane_a_write_sel_n,
  input  wire logic                        lane_b_write_sel_n,
  input  wire logic                        lane_c_write_sel_n,
  input  wire logic                        lane_d_write_sel_n,
  input  wire logic                        write_strobe_n,
  // Access control
  input  wire logic                        advance_or_load,
  input  wire logic                        clock_qualify_n,
  input  wire logic                        select_first_n,
  input  wire logic                        select_second,
  input  wire logic                        select_third_n,
  input  wire logic                        out_enable_n,
  input  wire logic                        burst_order_strap,
  // Data and parity pins
  input  wire logic [ssc_pkg::DATA_W-1:0]  data_in,
  input  wire logic [ssc_pkg::LANES-1:0]   parity_lines_in,
  output logic      [ssc_pkg::DATA_W-1:0]  data_out_reg,
  output logic      [ssc_pkg::LANES-1:0]   parity_lines_out_reg,
  output logic                             data_oe_reg
);
  import ssc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                    edge_ok;
  logic                    selected;
  logic [LANES-1:0]        lane_wr_n;
  logic                    interleave_reg;
  logic [ADDR_W-3:0]       base_upper_reg;
  logic [BURST_W-1:0]      base_low_reg;
  logic [BURST_W-1:0]      burst_cnt_reg;
  logic [BURST_W-1:0]      burst_cnt_next;
  logic [BURST_W-1:0]      burst_low;
  ssc_op_t                 burst_op_reg;
  ssc_op_t                 s1_op_reg;
  ssc_op_t                 s1_op_next;
  logic [ADDR_W-1:0]       s1_addr_reg;
  logic [ADDR_W-1:0]       s1_addr_next;
  logic [LANES-1:0]        s1_lanes_reg;
  ssc_op_t                 s2_op_reg;
  logic [ADDR_W-1:0]       s2_addr_reg;
  logic [LANES-1:0]        s2_lanes_reg;
  logic [LANES*LANE_W-1:0] wr_data;
  logic [LANES*LANE_W-1:0] rd_data;

  // qualified edge
  // Every stage below advances only on a recognised edge.
  assign edge_ok = ~clock_qualify_n;

  assign selected = ~select_first_n & select_second & ~select_third_n;

  assign lane_wr_n = {lane_d_write_sel_n, lane_c_write_sel_n,
                      lane_b_write_sel_n, lane_a_write_sel_n};

  // ----------------------------------------------------------------
  // Burst order strap
  // ----------------------------------------------------------------
  // strap held at reset
  // The strap is only taken while reset is high; later changes are ignored.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      interleave_reg <= burst_order_strap;
    end
  end

  // ----------------------------------------------------------------
  // Burst address generation
  // ----------------------------------------------------------------
  assign burst_cnt_next = burst_cnt_reg + 2'h1;

  assign burst_low = interleave_reg ? (base_low_reg ^ burst_cnt_next)
                                    : (base_low_reg + burst_cnt_next);

  // stretched edge holds state
  // An advance after a deselect has no burst to continue, so it stays idle.
  always_comb
  begin
    s1_op_next   = SSC_IDLE;
    s1_addr_next = s1_addr_reg;
    if (advance_or_load)
    begin
      s1_op_next   = burst_op_reg;
      s1_addr_next = {base_upper_reg, burst_low};
    end
    else if (selected)
    begin
      s1_op_next   = write_strobe_n ? SSC_READ : SSC_WRITE;
      s1_addr_next = {addr_upper, addr_bit_one, addr_bit_zero};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      burst_op_reg   <= SSC_IDLE;
      burst_cnt_reg  <= BURST_RST;
      base_low_reg   <= BURST_RST;
      base_upper_reg <= '0;
    end
    else if (edge_ok)
    begin
      if (advance_or_load)
      begin
        burst_cnt_reg <= burst_cnt_next;
      end
      else
      begin
        burst_op_reg   <= s1_op_next;
        burst_cnt_reg  <= BURST_RST;
        base_low_reg   <= {addr_bit_one, addr_bit_zero};
        base_upper_reg <= addr_upper;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pipeline stage one: address edge
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s1_op_reg    <= SSC_IDLE;
      s1_addr_reg  <= '0;
      s1_lanes_reg <= LANES_RST;
    end
    else if (edge_ok)
    begin
      s1_op_reg    <= s1_op_next;
      s1_addr_reg  <= s1_addr_next;
      s1_lanes_reg <= ~lane_wr_n;
    end
  end

  // ----------------------------------------------------------------
  // Pipeline stage two: array read edge
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s2_op_reg    <= SSC_IDLE;
      s2_addr_reg  <= '0;
      s2_lanes_reg <= LANES_RST;
    end
    else if (edge_ok)
    begin
      s2_op_reg    <= s1_op_reg;
      s2_addr_reg  <= s1_addr_reg;
      s2_lanes_reg <= s1_lanes_reg;
    end
  end

  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      wr_data[i*LANE_W +: LANE_W] = {parity_lines_in[i], data_in[i*BYTE_W +: BYTE_W]};
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // write data at second edge
  // masked lane write
  // Writing late, on the same edge that read data leaves, is what lets
  // reads and writes alternate with no idle cycle between them.
  ssc_mem #(
    .ADDR_W (ADDR_W)
  ) ssc_mem_inst (
    .ref_clk     (ref_clk),
    .wr_en       (edge_ok && !reset && (s2_op_reg == SSC_WRITE)),
    .wr_addr     (s2_addr_reg),
    .wr_lane_en  (s2_lanes_reg),
    .wr_data     (wr_data),
    .rd_en       (edge_ok && (s1_op_reg == SSC_READ)),
    .rd_addr     (s1_addr_reg),
    .rd_data_reg (rd_data)
  );

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // float on write or deselect
  // Output enable is sampled with the clock here so that every output
  // leaves a flip-flop; it therefore acts one edge late.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      data_oe_reg <= 1'b0;
    end
    else if (edge_ok)
    begin
      data_oe_reg <= (s2_op_reg == SSC_READ) && !out_enable_n;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      data_out_reg         <= '0;
      parity_lines_out_reg <= LANES_RST;
    end
    else if (edge_ok && (s2_op_reg == SSC_READ))
    begin
      for (int i = 0; i < LANES; i++)
      begin
        data_out_reg[i*BYTE_W +: BYTE_W] <= rd_data[i*LANE_W +: BYTE_W];
        parity_lines_out_reg[i]          <= rd_data[i*LANE_W + BYTE_W];
      end
    end
  end

endmodule : ssc_top
`default_nettype wire

// file: verif/ssc_properties.sv
// Concurrent checks on the pins of the memory control-input block.
// Assumes one clock and a synchronous, active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ssc_properties (
  // Clock and reset
  input wire logic                       ref_clk,
  input wire logic                       reset,
  // Control
  input wire logic                       advance_or_load,
  input wire logic                       clock_qualify_n,
  input wire logic                       select_first_n,
  input wire logic                       select_second,
  input wire logic                       select_third_n,
  input wire logic                       write_strobe_n,
  input wire logic                       out_enable_n,
  // Data
  input wire logic [ssc_pkg::DATA_W-1:0] data_out_reg,
  input wire logic                       data_oe_reg
);
  import ssc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic rec;
  logic ld;
  logic sel;
  assign rec = !clock_qualify_n && !reset;
  assign ld  = rec && !advance_or_load;
  assign sel = !select_first_n && select_second && !select_third_n;
  AST_RST_ZERO: assert property ($fell(reset) |-> !data_oe_reg && data_out_reg == '0)
    else $error("outputs not cleared by reset");
  AST_STALL_HOLD: assert property (rec == 1'b0 && !reset |=> $stable(data_out_reg) && $stable(data_oe_reg))
    else $error("outputs moved on an ignored edge");
  AST_READ_DRIVES: assert property ((ld && sel && write_strobe_n) ##1 rec ##1 (rec && !out_enable_n) |=> data_oe_reg)
    else $error("read data not driven two edges after load");
  AST_WRITE_FLOATS: assert property ((ld && sel && !write_strobe_n) ##1 rec ##1 rec |=> !data_oe_reg)
    else $error("pins driven in write data phase");
  AST_SEL_FIRST: assert property ((ld && select_first_n) ##1 rec ##1 rec |=> !data_oe_reg)
    else $error("driven with first select inactive");
  AST_SEL_SECOND: assert property ((ld && !select_second) ##1 rec ##1 rec |=> !data_oe_reg)
    else $error("driven with second select inactive");
  AST_SEL_THIRD: assert property ((ld && select_third_n) ##1 rec ##1 rec |=> !data_oe_reg)
    else $error("driven with third select inactive");
  AST_OE_MASK: assert property (rec && out_enable_n |=> !data_oe_reg)
    else $error("pins driven with output enable high");
  cover property (ld && sel && write_strobe_n);
  cover property (ld && sel && !write_strobe_n);
  cover property (clock_qualify_n [*3]);
endmodule : ssc_properties
bind ssc_top ssc_properties ssc_properties_inst (.ref_clk(ref_clk), .reset(reset),
  .advance_or_load(advance_or_load), .clock_qualify_n(clock_qualify_n),
  .select_first_n(select_first_n), .select_second(select_second),
  .select_third_n(select_third_n), .write_strobe_n(write_strobe_n),
  .out_enable_n(out_enable_n), .data_out_reg(data_out_reg), .data_oe_reg(data_oe_reg));
`default_nettype wire

// file: verif/ssc_ctrl_model.sv
// Controller model: turns a per-cycle command into strobe, selects and
// write data two qualified edges later. Assumes cmd changes after an edge.
`timescale 1ns/1ps
`default_nettype none
module ssc_ctrl_model (
  // Clock and stall
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clock_qualify_n,
  // Command: 0 deselect, 1 read, 2 write, 3 advance
  input  wire logic [1:0]  cmd,
  input  wire logic [35:0] wdata,
  // Pins
  output logic             write_strobe_n,
  output logic             advance_or_load,
  output logic             select_first_n,
  output logic             select_second,
  output logic             select_third_n,
  output logic [31:0]      data_in,
  output logic [3:0]       parity_lines_in
);
  logic        burst_wr_reg;
  logic        v0_reg;
  logic        v1_reg;
  logic [35:0] d0_reg;
  logic [35:0] d1_reg;
  assign write_strobe_n  = (cmd != 2'h2);
  assign advance_or_load = (cmd == 2'h3);
  assign select_first_n  = (cmd == 2'h0);
  assign select_second   = (cmd != 2'h0);
  assign select_third_n  = (cmd == 2'h0);
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      burst_wr_reg <= 1'b0;
      v0_reg       <= 1'b0;
      v1_reg       <= 1'b0;
    end
    else if (!clock_qualify_n)
    begin
      if (cmd != 2'h3)
        burst_wr_reg <= (cmd == 2'h2);
      v0_reg <= (cmd == 2'h2) || (cmd == 2'h3 && burst_wr_reg);
      v1_reg <= v0_reg;
      d0_reg <= wdata;
      d1_reg <= d0_reg;
    end
  end
  // A released bus shows the inverse, so a stale copy is never taken.
  assign {parity_lines_in, data_in} = v1_reg ? d1_reg : ~d1_reg;
endmodule : ssc_ctrl_model
`default_nettype wire

// file: verif/tb_ssc_top.sv
// Self-checking bench for the memory control-input block.
// Assumes the controller model drives strobe, selects and write data.
`timescale 1ns/1ps
`default_nettype none
module tb_ssc_top;
  import ssc_pkg::*;
  typedef struct {logic [1:0] cmd; logic [5:0] adr; logic [3:0] ln; logic [35:0] wd;
    logic oen; logic [1:0] chk; logic [35:0] exp;} ssc_row_t;
  ssc_row_t    rows [10];
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        clock_qualify_n = 1'b0;
  logic        out_enable_n = 1'b0;
  logic        burst_order_strap = 1'b1;
  logic [1:0]  cmd = 2'h0;
  logic [5:0]  adr = 6'h0;
  logic [3:0]  ln = 4'h0;
  logic [35:0] wdata = 36'h0;
  logic        wsn, aol, s1n, s2, s3n, data_oe_reg;
  logic [31:0] din, dout;
  logic [3:0]  pin, pout;
  int          err_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  always #10 ref_clk = ~ref_clk;
  ssc_top #(.ADDR_W(6)) ssc_top_inst (.ref_clk(ref_clk), .reset(reset),
    .addr_bit_zero(adr[0]), .addr_bit_one(adr[1]), .addr_upper(adr[5:2]),
    .lane_a_write_sel_n(ln[0]), .lane_b_write_sel_n(ln[1]), .lane_c_write_sel_n(ln[2]),
    .lane_d_write_sel_n(ln[3]), .write_strobe_n(wsn), .advance_or_load(aol),
    .clock_qualify_n(clock_qualify_n), .select_first_n(s1n), .select_second(s2),
    .select_third_n(s3n), .out_enable_n(out_enable_n), .burst_order_strap(burst_order_strap),
    .data_in(din), .parity_lines_in(pin), .data_out_reg(dout), .parity_lines_out_reg(pout),
    .data_oe_reg(data_oe_reg));
  ssc_ctrl_model ssc_ctrl_model_inst (.ref_clk(ref_clk), .reset(reset),
    .clock_qualify_n(clock_qualify_n), .cmd(cmd), .wdata(wdata), .write_strobe_n(wsn),
    .advance_or_load(aol), .select_first_n(s1n), .select_second(s2), .select_third_n(s3n),
    .data_in(din), .parity_lines_in(pin));
  task automatic check_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit
  task automatic check_word(input string nm, input logic [35:0] e);
    n_compared++;
    if ({pout, dout} !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, {pout, dout});
    end
  endtask : check_word
  task automatic issue(input logic [1:0] c, input logic [5:0] a, input logic [3:0] l,
                       input logic [35:0] d, input logic o);
    @(posedge ref_clk);
    #1;
    cmd = c;
    adr = a;
    ln = l;
    wdata = d;
    out_enable_n = o;
  endtask : issue
  task automatic end_of_test();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      end_of_test();
    end
  end
  initial
  begin
    rows = '{'{2'h2, 6'h04, 4'h0, 36'h9a1b2c3d4, 1'b0, 2'h1, 36'h0},
             '{2'h3, 6'h00, 4'h0, 36'h655667788, 1'b0, 2'h1, 36'h0},
             '{2'h2, 6'h04, 4'ha, 36'hfffffffff, 1'b0, 2'h1, 36'h0},
             '{2'h1, 6'h04, 4'h0, 36'h0, 1'b0, 2'h2, 36'hda1ffc3ff},
             '{2'h3, 6'h00, 4'h0, 36'h0, 1'b0, 2'h2, 36'h655667788},
             '{2'h0, 6'h00, 4'h0, 36'h0, 1'b0, 2'h1, 36'h0},
             '{2'h1, 6'h05, 4'h0, 36'h0, 1'b0, 2'h1, 36'h0},
             '{2'h1, 6'h05, 4'h0, 36'h0, 1'b0, 2'h2, 36'h655667788},
             '{2'h0, 6'h00, 4'h0, 36'h0, 1'b1, 2'h0, 36'h0},
             '{2'h0, 6'h00, 4'h0, 36'h0, 1'b0, 2'h0, 36'h0}};
    repeat (10) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    for (int i = 0; i < 13; i++)
    begin
      if (i < 10)
        issue(rows[i].cmd, rows[i].adr, rows[i].ln, rows[i].wd, rows[i].oen);
      else
        issue(2'h0, 6'h0, 4'h0, 36'h0, 1'b0);
      if (i >= 3 && rows[i-3].chk != 2'h0)
      begin
        check_bit("data_oe_reg", rows[i-3].chk[1], data_oe_reg);
        if (rows[i-3].chk[1])
          check_word("read data", rows[i-3].exp);
      end
    end
    // Read held across three ignored edges; the stalled write must not land.
    issue(2'h1, 6'h04, 4'h0, 36'h0, 1'b0);
    issue(2'h2, 6'h04, 4'h0, 36'h0, 1'b0);
    clock_qualify_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    clock_qualify_n = 1'b0;
    cmd = 2'h0;
    repeat (2) issue(2'h0, 6'h0, 4'h0, 36'h0, 1'b0);
    check_bit("data_oe_reg", 1'b1, data_oe_reg);
    check_word("stalled read", 36'hda1ffc3ff);
    // Advance straight after a deselect stays idle.
    issue(2'h3, 6'h0, 4'h0, 36'h0, 1'b0);
    repeat (3) issue(2'h0, 6'h0, 4'h0, 36'h0, 1'b0);
    check_bit("data_oe_reg", 1'b0, data_oe_reg);
    // Second reset with the strap low selects linear order.
    burst_order_strap = 1'b0;
    reset = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    check_bit("data_oe_reg", 1'b0, data_oe_reg);
    check_word("reset data", 36'h0);
    issue(2'h2, 6'h05, 4'h0, 36'h102030405, 1'b0);
    issue(2'h3, 6'h00, 4'h0, 36'h206070809, 1'b0);
    issue(2'h1, 6'h06, 4'h0, 36'h0, 1'b0);
    issue(2'h1, 6'h04, 4'h0, 36'h0, 1'b0);
    repeat (2) issue(2'h0, 6'h0, 4'h0, 36'h0, 1'b0);
    check_word("linear burst", 36'h206070809);
    // Word 4 keeps its value: the write shown only on ignored edges never landed.
    issue(2'h0, 6'h0, 4'h0, 36'h0, 1'b0);
    check_word("stalled write", 36'hda1ffc3ff);
    end_of_test();
  end
endmodule : tb_ssc_top
`default_nettype wire
